/* File: design/sic_regs.svh */
/*
 * Register offsets, field positions and reset values of the input-clock
 * select stage. Assumes it is included by bare name from design files only.
 */
`ifndef SIC_REGS_SVH
`define SIC_REGS_SVH

`define SIC_OFF_PIN_CONTROL 8'h00
`define SIC_OFF_RATE_GEN_ONE 8'h04
`define SIC_OFF_RATE_GEN_TWO 8'h08
`define SIC_OFF_PORT_CONTROL 8'h0c
`define SIC_OFF_STATUS 8'h10

`define SIC_CLOCK_MODE_ENABLE_BIT 7
`define SIC_TX_PIN_POLARITY_BIT 1
`define SIC_RX_PIN_POLARITY_BIT 0
`define SIC_CLOCK_SOURCE_SELECT_BIT 13
`define SIC_FRAME_PERIOD_MSB 11
`define SIC_DIVIDE_MSB 7
`define SIC_TX_RESET_N_BIT 0
`define SIC_GEN_ENABLE_BIT 6
`define SIC_FRAME_ENABLE_BIT 7

`define SIC_PIN_CONTROL_RESET 16'h0000
`define SIC_RATE_GEN_ONE_RESET 16'h0001
`define SIC_RATE_GEN_TWO_RESET 16'h2000
`define SIC_PORT_CONTROL_RESET 16'h0000

`endif

/* File: design/sic_pkg.sv */
/*
 * Types shared by the input-clock select stage: source codes, bus and pin
 * carriers and the packed state of each module.
 * Assumes AHB-Lite with 32-bit data and a single slave.
 */
package sic_pkg;

   typedef enum logic [1:0] {
      SIC_SRC_NONE = 2'b00,
      SIC_SRC_RX = 2'b01,
      SIC_SRC_LSP = 2'b10,
      SIC_SRC_TX = 2'b11
   } sic_src_e;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } sic_ahb_req_s;

   typedef struct packed {
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } sic_ahb_rsp_s;

   typedef struct packed {
      logic low_speed_peripheral_clock;
      logic receive_clock_pin;
      logic transmit_clock_pin;
   } sic_pins_s;

   typedef struct packed {
      logic generated_bit_clock;
      logic bit_clock_tick;
      logic generated_frame_sync;
      logic transmitter_reset_n;
   } sic_gen_s;

   typedef struct packed {
      logic prev;
      logic primed;
   } sic_edge_s;

   typedef struct packed {
      logic [15:0] pin_control;
      logic [15:0] rate_gen_control_one;
      logic [15:0] rate_gen_control_two;
      logic [15:0] port_control;
      logic dp_write;
      logic [7:0] dp_addr;
      sic_ahb_rsp_s rsp;
      logic [7:0] div_count;
      logic [11:0] frame_count;
      sic_gen_s gen;
   } sic_state_s;

endpackage : sic_pkg

/* File: design/sic_edge_pick.sv */
/*
 * Conditional inversion and rising-edge detection of one clock source level.
 * Assumes the level is already synchronous to hclk.
 */
`timescale 1ns/1ps
`default_nettype none

module sic_edge_pick (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic pin_level,
   input wire logic invert,
   output logic cond_level,
   output logic edge_pulse
);
   import sic_pkg::*;

   sic_edge_s s;
   sic_edge_s next_s;

   // Inverting ahead of the detector keeps one edge type downstream.
   assign cond_level = pin_level ^ invert;
   // No edge is reported until one sample has been seen after reset.
   assign edge_pulse = s.primed & cond_level & ~s.prev;

   always_comb begin
      next_s = s;
      next_s.prev = cond_level;
      next_s.primed = 1'b1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

endmodule : sic_edge_pick

`default_nettype wire

/* File: design/sic_clock_select.sv */
/*
 * Input-clock select, edge polarity and bit-clock/frame-sync generator
 * with an AHB-Lite register slave.
 * Assumes pins and the low-speed clock level are synchronous to hclk and
 * toggle at most once per two hclk cycles.
 */

// Overview of operation
// - Mode enable clear with source select set picks the low-speed peripheral clock, the reset default; both clear is reserved.
// - Mode enable set with source select clear picks the receive clock pin.
// - Both mode bits set picks the transmit clock pin.
// - Transmit pin with polarity zero advances the generator on its rising edges.
// - Transmit pin with polarity one advances the generator on its falling edges.
// - Receive pin with polarity zero advances the generator on its falling edges.
// - Receive pin with polarity one advances the generator on its rising edges.
// - Only the selected pin's polarity bit decides the active edge.
// - The bit clock comes from the selected input clock and nothing else.
// - The frame sync is produced from the same selected input clock.
// - The bit clock is the input clock divided by the divide value plus one, reset to one.
`timescale 1ns/1ps
`default_nettype none

`include "sic_regs.svh"

module sic_clock_select (
   input wire logic hclk,
   input wire logic hresetn,
   input wire sic_pkg::sic_ahb_req_s ahb_req,
   output sic_pkg::sic_ahb_rsp_s ahb_rsp,
   input wire sic_pkg::sic_pins_s pins,
   output sic_pkg::sic_gen_s gen_out
);
   import sic_pkg::*;

   sic_state_s s;
   sic_state_s next_s;
   sic_src_e src_sel;
   logic lsp_level, rx_level, tx_level;
   logic lsp_edge, rx_edge, tx_edge;
   logic src_edge;
   logic src_level;
   logic gen_run;
   logic take;
   logic [7:0] divide;
   logic [11:0] frame_period;

   assign ahb_rsp = s.rsp;
   assign gen_out = s.gen;
   assign divide = s.rate_gen_control_one[`SIC_DIVIDE_MSB:0];
   assign frame_period = s.rate_gen_control_two[`SIC_FRAME_PERIOD_MSB:0];
   assign take = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;

   // source decode from the two mode bits.
   always_comb begin
      unique case ({s.pin_control[`SIC_CLOCK_MODE_ENABLE_BIT],
                    s.rate_gen_control_two[`SIC_CLOCK_SOURCE_SELECT_BIT]})
         2'b01: src_sel = SIC_SRC_LSP;
         2'b10: src_sel = SIC_SRC_RX;
         2'b11: src_sel = SIC_SRC_TX;
         2'b00: src_sel = SIC_SRC_NONE;
      endcase
   end

   // low-speed clock is used as is.
   sic_edge_pick u_lsp_edge (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_level(pins.low_speed_peripheral_clock),
      .invert(1'b0),
      .cond_level(lsp_level),
      .edge_pulse(lsp_edge)
   );

   // receive pin is inverted while its polarity bit is zero.
   sic_edge_pick u_rx_edge (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_level(pins.receive_clock_pin),
      .invert(~s.pin_control[`SIC_RX_PIN_POLARITY_BIT]),
      .cond_level(rx_level),
      .edge_pulse(rx_edge)
   );

   // transmit pin is inverted while its polarity bit is one.
   sic_edge_pick u_tx_edge (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_level(pins.transmit_clock_pin),
      .invert(s.pin_control[`SIC_TX_PIN_POLARITY_BIT]),
      .cond_level(tx_level),
      .edge_pulse(tx_edge)
   );

   // only the chosen source's conditioned edge reaches the divider.
   always_comb begin
      unique case (src_sel)
         SIC_SRC_LSP: begin
            src_edge = lsp_edge;
            src_level = lsp_level;
         end
         SIC_SRC_RX: begin
            src_edge = rx_edge;
            src_level = rx_level;
         end
         SIC_SRC_TX: begin
            src_edge = tx_edge;
            src_level = tx_level;
         end
         SIC_SRC_NONE: begin
            src_edge = 1'b0;
            src_level = 1'b0;
         end
      endcase
   end

   // The reserved mode stops the generator rather than guess a source.
   assign gen_run = s.port_control[`SIC_GEN_ENABLE_BIT] && (src_sel != SIC_SRC_NONE);

   always_comb begin
      next_s = s;
      next_s.gen.bit_clock_tick = 1'b0;
      // Write data phase lands first so a following read sees the new value.
      if (s.dp_write) begin
         unique case (s.dp_addr)
            `SIC_OFF_PIN_CONTROL: next_s.pin_control = ahb_req.hwdata[15:0];
            `SIC_OFF_RATE_GEN_ONE: next_s.rate_gen_control_one = ahb_req.hwdata[15:0];
            `SIC_OFF_RATE_GEN_TWO: next_s.rate_gen_control_two = ahb_req.hwdata[15:0];
            `SIC_OFF_PORT_CONTROL: next_s.port_control = ahb_req.hwdata[15:0];
            default: next_s.pin_control = s.pin_control;
         endcase
      end
      next_s.dp_write = take & ahb_req.hwrite;
      next_s.dp_addr = ahb_req.haddr[7:0];
      next_s.rsp.hreadyout = 1'b1;
      next_s.rsp.hresp = 1'b0;
      next_s.rsp.hrdata = 32'h0000_0000;
      if (take && !ahb_req.hwrite) begin
         unique case (ahb_req.haddr[7:0])
            `SIC_OFF_PIN_CONTROL: next_s.rsp.hrdata = {16'h0000, next_s.pin_control};
            `SIC_OFF_RATE_GEN_ONE: next_s.rsp.hrdata = {16'h0000, next_s.rate_gen_control_one};
            `SIC_OFF_RATE_GEN_TWO: next_s.rsp.hrdata = {16'h0000, next_s.rate_gen_control_two};
            `SIC_OFF_PORT_CONTROL: next_s.rsp.hrdata = {16'h0000, next_s.port_control};
            `SIC_OFF_STATUS: next_s.rsp.hrdata = {26'h000_0000, s.gen.transmitter_reset_n,
                                                  s.gen.generated_frame_sync,
                                                  s.gen.generated_bit_clock,
                                                  src_sel, (src_sel == SIC_SRC_NONE)};
            default: next_s.rsp.hrdata = 32'h0000_0000;
         endcase
      end
      // the transmitter enable is only what software last wrote.
      next_s.gen.transmitter_reset_n = s.port_control[`SIC_TX_RESET_N_BIT];
      if (!gen_run) begin
         next_s.div_count = 8'h00;
         next_s.frame_count = 12'h000;
         next_s.gen.generated_bit_clock = 1'b0;
         next_s.gen.generated_frame_sync = 1'b0;
      end else begin
         // divide by the divide value plus one, high for the first half.
         if (divide == 8'h00) begin
            next_s.gen.generated_bit_clock = src_level;
            next_s.gen.bit_clock_tick = src_edge;
         end else if (src_edge) begin
            if (s.div_count >= divide) begin
               next_s.div_count = 8'h00;
               next_s.gen.bit_clock_tick = 1'b1;
            end else begin
               next_s.div_count = s.div_count + 8'h01;
            end
            next_s.gen.generated_bit_clock = (next_s.div_count <= {1'b0, divide[7:1]});
         end
         // frame sync steps on bit-clock ticks from the same source.
         if (!s.port_control[`SIC_FRAME_ENABLE_BIT]) begin
            next_s.frame_count = 12'h000;
            next_s.gen.generated_frame_sync = 1'b0;
         end else if (next_s.gen.bit_clock_tick) begin
            if (s.frame_count >= frame_period) begin
               next_s.frame_count = 12'h000;
               next_s.gen.generated_frame_sync = 1'b1;
            end else begin
               next_s.frame_count = s.frame_count + 12'h001;
               next_s.gen.generated_frame_sync = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
         s.pin_control <= `SIC_PIN_CONTROL_RESET;
         s.rate_gen_control_one <= `SIC_RATE_GEN_ONE_RESET;
         s.rate_gen_control_two <= `SIC_RATE_GEN_TWO_RESET;
         s.port_control <= `SIC_PORT_CONTROL_RESET;
         s.rsp.hreadyout <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   lsp_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (!s.pin_control[`SIC_CLOCK_MODE_ENABLE_BIT] && s.rate_gen_control_two[`SIC_CLOCK_SOURCE_SELECT_BIT])
      |-> (src_sel == SIC_SRC_LSP) && (src_edge == lsp_edge))
      else $error("low-speed clock not selected");

   rx_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (s.pin_control[`SIC_CLOCK_MODE_ENABLE_BIT] && !s.rate_gen_control_two[`SIC_CLOCK_SOURCE_SELECT_BIT])
      |-> (src_sel == SIC_SRC_RX) && (src_edge == rx_edge))
      else $error("receive pin not selected");

   tx_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (s.pin_control[`SIC_CLOCK_MODE_ENABLE_BIT] && s.rate_gen_control_two[`SIC_CLOCK_SOURCE_SELECT_BIT])
      |-> (src_sel == SIC_SRC_TX) && (src_edge == tx_edge))
      else $error("transmit pin not selected");

   tx_rise_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (src_sel == SIC_SRC_TX) && !s.pin_control[`SIC_TX_PIN_POLARITY_BIT]
      && $stable(s.pin_control) && $rose(pins.transmit_clock_pin) |-> src_edge)
      else $error("transmit rising edge missed");

   tx_fall_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (src_sel == SIC_SRC_TX) && s.pin_control[`SIC_TX_PIN_POLARITY_BIT]
      && $stable(s.pin_control) |-> (src_edge == $fell(pins.transmit_clock_pin)))
      else $error("transmit falling edge wrong");

   rx_fall_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (src_sel == SIC_SRC_RX) && !s.pin_control[`SIC_RX_PIN_POLARITY_BIT]
      && $stable(s.pin_control) |-> (src_edge == $fell(pins.receive_clock_pin)))
      else $error("receive falling edge wrong");

   rx_rise_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (src_sel == SIC_SRC_RX) && s.pin_control[`SIC_RX_PIN_POLARITY_BIT]
      && $stable(s.pin_control) && $rose(pins.receive_clock_pin) |-> src_edge)
      else $error("receive rising edge missed");

   pin_isolation_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (src_sel == SIC_SRC_RX) && $stable(pins.receive_clock_pin) && $stable(s.pin_control) |-> !src_edge)
      else $error("edge without receive pin change");

   divide_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
      gen_run && src_edge && (divide != 8'h00) && (s.div_count == divide)
      |=> (s.div_count == 8'h00) && s.gen.bit_clock_tick)
      else $error("divider did not wrap at divide value");

   bclk_source_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(s.gen.bit_clock_tick) && $stable(s.rate_gen_control_one) |-> $past(src_edge))
      else $error("bit clock tick without source edge");

   fsync_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(s.gen.generated_frame_sync) |-> s.gen.bit_clock_tick)
      else $error("frame sync not on a bit clock tick");

   // The edge detectors need one settled sample after reset, so the low-speed rising-edge check skips that first cycle.
   lsp_rise_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(hresetn) && (src_sel == SIC_SRC_LSP) && $rose(pins.low_speed_peripheral_clock)
      |-> src_edge)
      else $error("low-speed rising edge missed");

   lsp_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (src_sel == SIC_SRC_LSP) && $stable(pins.low_speed_peripheral_clock)
      |-> !src_edge)
      else $error("edge without low-speed clock change");

   reserved_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (src_sel == SIC_SRC_NONE)
      |=> !s.gen.generated_bit_clock && !s.gen.bit_clock_tick)
      else $error("reserved mode left the generator running");

   // A polarity bit of the other pin must never create an edge on the chosen one.
   tx_own_polarity_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (src_sel == SIC_SRC_TX) && $stable(pins.transmit_clock_pin)
      && $stable(s.pin_control[`SIC_TX_PIN_POLARITY_BIT]) |-> !src_edge)
      else $error("transmit source edge from a foreign bit");

   rx_own_polarity_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (src_sel == SIC_SRC_RX) && $stable(pins.receive_clock_pin)
      && $stable(s.pin_control[`SIC_RX_PIN_POLARITY_BIT]) |-> !src_edge)
      else $error("receive source edge from a foreign bit");

   stopped_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !s.port_control[`SIC_GEN_ENABLE_BIT]
      |=> !s.gen.generated_bit_clock && !s.gen.bit_clock_tick && !s.gen.generated_frame_sync)
      else $error("stopped generator still drives outputs");

   tick_needs_edge_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s.gen.bit_clock_tick
      |-> $past(src_edge) && $past(gen_run))
      else $error("bit clock tick without a running source edge");

   bclk_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      gen_run && (divide != 8'h00) && !src_edge
      |=> $stable(s.gen.generated_bit_clock))
      else $error("bit clock moved without a source edge");

   // Divide value zero passes every source edge straight through.
   zero_divide_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
      gen_run && (divide == 8'h00)
      |=> (s.gen.bit_clock_tick == $past(src_edge)))
      else $error("undivided tick does not follow the source");

   tick_single_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s.gen.bit_clock_tick
      |=> !s.gen.bit_clock_tick)
      else $error("bit clock tick longer than one cycle");

   count_bound_a: assert property (@(posedge hclk) disable iff (!hresetn)
      gen_run && (divide != 8'h00) && (s.div_count < divide)
      |=> $changed(divide) || (s.div_count <= divide))
      else $error("divider count passed the divide value");

   frame_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !s.port_control[`SIC_FRAME_ENABLE_BIT]
      |=> !s.gen.generated_frame_sync)
      else $error("frame sync while frame logic is off");

   frame_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $changed(s.gen.generated_frame_sync)
      |-> s.gen.bit_clock_tick || !$past(gen_run) || !$past(s.port_control[`SIC_FRAME_ENABLE_BIT]))
      else $error("frame sync moved off a bit clock tick");

   // Hardware only forwards the enable; the ordering is left to software.
   tx_enable_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(hresetn)
      |-> (s.gen.transmitter_reset_n == $past(s.port_control[`SIC_TX_RESET_N_BIT])))
      else $error("transmitter enable does not follow its bit");

endmodule : sic_clock_select

`default_nettype wire

/* File: verif/sic_pins_model.sv */
/* Far-side clock source model: drives the low-speed clock and both clock pins.
   Assumes the bench calls its tasks on a rising hclk edge. */
`timescale 1ns/1ps
`default_nettype none
module sic_pins_model (
   input wire logic hclk,
   output var sic_pkg::sic_pins_s pins
);
   import sic_pkg::*;
   initial pins = '0;
   // Three cycles a level keeps above the two-cycle minimum the inputs need.
   task automatic drive(input int sel, input logic v);
      @(posedge hclk);
      if (sel == 0) begin
         pins.low_speed_peripheral_clock <= v;
      end else if (sel == 1) begin
         pins.receive_clock_pin <= v;
      end else begin
         pins.transmit_clock_pin <= v;
      end
      repeat (2) @(posedge hclk);
   endtask : drive
   // The source stands still between bursts, as a real device clock would.
   task automatic burst(input int sel, input int n);
      for (int i = 0; i < n; i++) begin
         drive(sel, 1'b1);
         drive(sel, 1'b0);
      end
   endtask : burst
endmodule : sic_pins_model
`default_nettype wire

/* File: verif/srg_input_clock_select_bench.sv */
/* Self-checking bench for the input-clock select stage.
   Assumes one slave on the bus; the master waits for hready however long it takes. */
`timescale 1ns/1ps
`default_nettype none
module srg_input_clock_select_bench;
   import sic_pkg::*;
   logic hclk;
   logic hresetn;
   sic_ahb_req_s ahb_req;
   sic_ahb_rsp_s ahb_rsp;
   sic_pins_s pins;
   sic_gen_s gen_out;
   int miscompares = 0;
   int n_compared = 0;
   int n_ticks = 0;
   int n_frames = 0;
   logic fs_q = 1'b0;
   logic [31:0] rd;
   logic rsp_err;
   sic_clock_select u_sic_clock_select (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
      .pins(pins), .gen_out(gen_out));
   sic_pins_model u_sic_pins_model (.hclk(hclk), .pins(pins));
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   // Counted on the falling edge so the flops have settled.
   always @(negedge hclk) begin
      if (gen_out.bit_clock_tick === 1'b1) n_ticks++;
      if (gen_out.generated_frame_sync === 1'b1 && fs_q === 1'b0) n_frames++;
      fs_q = gen_out.generated_frame_sync;
   end
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : cmp_word
   task automatic cmp_count(input int got, input int exp, input string what);
      n_compared++;
      if (got != exp) begin
         miscompares++;
         $display("unexpected at %0t: %s got %0d want %0d", $time, what, got, exp);
      end
   endtask : cmp_count
   task automatic close_out;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out
   // One single transfer; entered and left on a rising edge.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      logic r;
      ahb_req.hsel <= 1'b1;
      ahb_req.haddr <= {24'h000000, a};
      ahb_req.htrans <= 2'b10;
      ahb_req.hwrite <= w;
      do begin
         @(negedge hclk);
         r = ahb_rsp.hreadyout;
         @(posedge hclk);
      end while (r !== 1'b1);
      ahb_req.hsel <= 1'b0;
      ahb_req.htrans <= 2'b00;
      ahb_req.hwdata <= wd;
      do begin
         @(negedge hclk);
         r = ahb_rsp.hreadyout;
         rd = ahb_rsp.hrdata;
         rsp_err = ahb_rsp.hresp;
         @(posedge hclk);
      end while (r !== 1'b1);
   endtask : bus
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
      bus(1'b0, a, 32'h00000000);
      cmp_word(rd & mask, exp, "read");
      cmp_word({31'h00000000, rsp_err}, 32'h00000000, "response");
   endtask : rd_chk
   task automatic out_chk(input logic got_sel, input logic exp);
      // The transmitter enable reaches its output one cycle after the register write lands.
      repeat (2) @(negedge hclk);
      cmp_word({31'h00000000, got_sel ? gen_out.transmitter_reset_n : gen_out.generated_bit_clock},
         {31'h00000000, exp}, "output");
      @(posedge hclk);
   endtask : out_chk
   task automatic test_regs;
      rd_chk(8'h00, 32'h00000000, 32'hffffffff);
      rd_chk(8'h04, 32'h00000001, 32'hffffffff);
      rd_chk(8'h08, 32'h00002000, 32'hffffffff);
      rd_chk(8'h10, 32'h00000004, 32'h0000003f);
      bus(1'b1, 8'h00, 32'hffff0082);
      rd_chk(8'h00, 32'h00000082, 32'hffffffff);
      bus(1'b1, 8'h10, 32'h0000ffff);
      rd_chk(8'h10, 32'h00000006, 32'h00000007);
      bus(1'b1, 8'h20, 32'h12345678);
      rd_chk(8'h20, 32'h00000000, 32'hffffffff);
      $display("regs done");
   endtask : test_regs
   task automatic test_source;
      logic [15:0] pc [4] = '{16'h0000, 16'h0081, 16'h0080, 16'h0000};
      logic [15:0] r2 [4] = '{16'h2000, 16'h0000, 16'h2000, 16'h0000};
      logic [2:0] st [4] = '{3'b100, 3'b010, 3'b110, 3'b001};
      bus(1'b1, 8'h04, 32'h00000001);
      bus(1'b1, 8'h0c, 32'h00000040);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, 8'h00, {16'h0000, pc[i]});
         bus(1'b1, 8'h08, {16'h0000, r2[i]});
         rd_chk(8'h10, {29'h00000000, st[i]}, 32'h00000007);
         n_ticks = 0;
         u_sic_pins_model.burst(i % 3, 8);
         cmp_count(n_ticks, (i == 3) ? 0 : 4, "ticks on source");
         for (int j = 0; j < 3; j++) begin
            if (j != i % 3) u_sic_pins_model.burst(j, 8);
         end
         cmp_count(n_ticks, (i == 3) ? 0 : 4, "ticks off source");
      end
      $display("source done");
   endtask : test_source
   task automatic test_polarity;
      logic [15:0] pc [4] = '{16'h0082, 16'h0081, 16'h0081, 16'h0082};
      logic [15:0] r2 [4] = '{16'h0000, 16'h0000, 16'h2000, 16'h2000};
      logic inv [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
      bus(1'b1, 8'h04, 32'h00000000);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, 8'h00, {16'h0000, pc[i]});
         bus(1'b1, 8'h08, {16'h0000, r2[i]});
         u_sic_pins_model.drive(1 + i / 2, 1'b0);
         u_sic_pins_model.drive(1 + i / 2, 1'b1);
         out_chk(1'b0, ~inv[i]);
         u_sic_pins_model.drive(1 + i / 2, 1'b0);
         out_chk(1'b0, inv[i]);
      end
      $display("polarity done");
   endtask : test_polarity
   task automatic test_divide;
      int dv [2] = '{3, 255};
      bus(1'b1, 8'h00, 32'h00000000);
      bus(1'b1, 8'h08, 32'h00002000);
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, 8'h04, dv[i]);
         n_ticks = 0;
         u_sic_pins_model.burst(0, (dv[i] + 1) * (i == 0 ? 3 : 1));
         cmp_count(n_ticks, i == 0 ? 3 : 1, "divided ticks");
      end
      $display("divide done");
   endtask : test_divide
   task automatic test_frame;
      bus(1'b1, 8'h04, 32'h00000001);
      bus(1'b1, 8'h08, 32'h00002003);
      bus(1'b1, 8'h0c, 32'h000000c0);
      u_sic_pins_model.burst(0, 8);
      n_frames = 0;
      u_sic_pins_model.burst(0, 32);
      cmp_count(n_frames, 4, "frame syncs");
      $display("frame done");
   endtask : test_frame
   task automatic test_tx_reset;
      bus(1'b1, 8'h0c, 32'h00000040);
      out_chk(1'b1, 1'b0);
      bus(1'b1, 8'h04, 32'h00000001);
      bus(1'b1, 8'h0c, 32'h00000041);
      out_chk(1'b1, 1'b1);
      $display("tx reset done");
   endtask : test_tx_reset
   initial begin
      ahb_req = '0;
      ahb_req.hready = 1'b1;
      ahb_req.hsize = 3'b010;
      hresetn = 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      test_regs();
      test_source();
      test_polarity();
      test_divide();
      test_frame();
      test_tx_reset();
      close_out();
   end
   // The tests need about 2600 cycles; this limit leaves wide margin.
   initial begin
      repeat (30000) @(posedge hclk);
      miscompares++;
      $display("unexpected at %0t: watchdog expired", $time);
      close_out();
   end
endmodule : srg_input_clock_select_bench
`default_nettype wire
